// ### rtl/vid_softstart_pkg.sv
// constants for the identification-code and soft-start sequencer
package vid_softstart_pkg;
	localparam int unsigned MCLK_PERIOD_NS = 40;
	localparam int unsigned SW_PERIOD_NS = 4000;
	localparam int unsigned SW_PERIOD_CYC = (SW_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [7:0] SW_CNT_LAST = 8'(SW_PERIOD_CYC - 1);
	localparam logic [4:0] CODE_NO_LOAD = 5'h1f;
	localparam logic [4:0] CODE_RESET = 5'h1f;
	localparam logic [10:0] REF_TOP_MV = 11'h60e;
	localparam logic [10:0] REF_STEP_MV = 11'h019;
	localparam logic [10:0] SS_CNT_LAST = 11'h7ff;
	localparam logic [11:0] SS_SPAN = 12'h800;
	localparam logic [7:0] RAMP_I_TOP_UA = 8'ha0;
	localparam int unsigned RAMP_NUM = 7;
	localparam int unsigned RAMP_DEN = 5;
	localparam int unsigned SS_SHIFT = 11;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_STATE = 4'h8;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam int unsigned EV_SHUTDOWN = 0;
	localparam int unsigned EV_SS_DONE = 1;
	localparam int unsigned EV_CODE_TAKEN = 2;
	localparam int unsigned EV_POWER_FAIL = 3;
	typedef enum logic [1:0] {
		ST_SHUTDOWN,
		ST_SOFTSTART,
		ST_RUN
	} seq_state_t;
endpackage

// ### rtl/vid_softstart_sequencer.sv
// supervisory core: code sampling, reference stepping, soft-start, power-good
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module vid_softstart_sequencer (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_supply_por_ok,
	input wire logic i_enable_above,
	input wire logic i_freq_select_disable,
	input wire logic [4:0] i_voltage_id_code,
	input wire logic i_output_above_uv,
	input wire logic i_fault,
	input wire logic [3:0] i_pwm_mod,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_irq,
	output logic [3:0] o_pwm_o,
	output logic [3:0] o_pwm_oe,
	output logic o_power_ok_output_o,
	output logic o_power_ok_output_oe,
	output logic [10:0] o_dac_mv,
	output logic [11:0] o_ramp_mv,
	output logic [7:0] o_ramp_ua,
	output logic [11:0] o_reg_target_mv,
	output logic o_soft_start
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [7:0] sw_cnt_q;
	logic tick;
	logic [4:0] sampled_q;
	logic [4:0] pend_code_q;
	logic pend_valid_q;
	logic [4:0] target_code_q;
	logic [4:0] cur_code_q;
	logic step_phase_q;
	logic code_taken;
	vid_softstart_pkg::seq_state_t state_q;
	logic enable_ok;
	logic [10:0] ss_cnt_q;
	logic [10:0] dac_w;
	logic [24:0] ramp_prod;
	logic [11:0] ramp_w;
	logic [19:0] iramp_prod;
	logic pg_q;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [3:0] events;
	logic ss_done;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// oscillator: one tick per channel-1 switching cycle, also the phase clock
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sw_cnt_q <= 8'h00;
		end else if (!i_freq_select_disable) begin
			sw_cnt_q <= 8'h00;
		end else if (sw_cnt_q == vid_softstart_pkg::SW_CNT_LAST) begin
			sw_cnt_q <= 8'h00;
		end else begin
			sw_cnt_q <= sw_cnt_q + 8'h01;
		end
	end
	assign tick = i_freq_select_disable && (sw_cnt_q == vid_softstart_pkg::SW_CNT_LAST);

	// code sampling and one-cycle validation
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sampled_q <= vid_softstart_pkg::CODE_RESET;
			pend_code_q <= vid_softstart_pkg::CODE_RESET;
			pend_valid_q <= 1'b0;
			target_code_q <= vid_softstart_pkg::CODE_RESET;
		end else if (tick) begin
			sampled_q <= i_voltage_id_code;
			if (pend_valid_q && i_voltage_id_code == pend_code_q) begin
				target_code_q <= pend_code_q;
				pend_valid_q <= 1'b0;
			end else if (i_voltage_id_code != target_code_q) begin
				pend_code_q <= i_voltage_id_code;
				pend_valid_q <= 1'b1;
			end else begin
				pend_valid_q <= 1'b0;
			end
		end
	end
	assign code_taken = tick && pend_valid_q && (i_voltage_id_code == pend_code_q);

	// steps whenever regulating, soft-start too; in shutdown nothing regulates, so jump
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cur_code_q <= vid_softstart_pkg::CODE_RESET;
			step_phase_q <= 1'b0;
		end else if (state_q == vid_softstart_pkg::ST_SHUTDOWN) begin
			cur_code_q <= target_code_q;
			step_phase_q <= 1'b0;
		end else if (cur_code_q == target_code_q) begin
			step_phase_q <= 1'b0;
		end else if (tick) begin
			step_phase_q <= !step_phase_q;
			if (step_phase_q) begin
				if (target_code_q > cur_code_q) begin
					cur_code_q <= cur_code_q + 5'h01;
				end else begin
					cur_code_q <= cur_code_q - 5'h01;
				end
			end
		end
	end

	assign enable_ok = i_supply_por_ok && i_enable_above && i_freq_select_disable
		&& (sampled_q != vid_softstart_pkg::CODE_NO_LOAD);
	assign ss_done = tick && (ss_cnt_q == vid_softstart_pkg::SS_CNT_LAST);

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= vid_softstart_pkg::ST_SHUTDOWN;
		end else if (!enable_ok) begin
			state_q <= vid_softstart_pkg::ST_SHUTDOWN;
		end else begin
			unique case (state_q)
				vid_softstart_pkg::ST_SHUTDOWN: begin
					state_q <= vid_softstart_pkg::ST_SOFTSTART;
				end
				vid_softstart_pkg::ST_SOFTSTART: begin
					if (ss_done) begin
						state_q <= vid_softstart_pkg::ST_RUN;
					end
				end
				vid_softstart_pkg::ST_RUN: begin
					state_q <= vid_softstart_pkg::ST_RUN;
				end
				default: begin
					state_q <= vid_softstart_pkg::ST_SHUTDOWN;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ss_cnt_q <= 11'h000;
		end else if (state_q != vid_softstart_pkg::ST_SOFTSTART) begin
			ss_cnt_q <= 11'h000;
		end else if (tick) begin
			ss_cnt_q <= ss_cnt_q + 11'h001;
		end
	end

	assign dac_w = vid_softstart_pkg::REF_TOP_MV
		- 11'(vid_softstart_pkg::REF_STEP_MV * {6'h00, cur_code_q});
	// divide by five is a constant divider; cheaper than a wider multiplier
	assign ramp_prod = 25'(o_dac_mv) * 25'(ss_cnt_q) * 25'(vid_softstart_pkg::RAMP_NUM);
	assign ramp_w = 12'((ramp_prod >> vid_softstart_pkg::SS_SHIFT)
		/ 25'(vid_softstart_pkg::RAMP_DEN));
	assign iramp_prod = 20'(vid_softstart_pkg::RAMP_I_TOP_UA)
		* 20'(vid_softstart_pkg::SS_SPAN - {1'b0, ss_cnt_q});

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_dac_mv <= 11'h000;
			o_ramp_mv <= 12'h000;
			o_ramp_ua <= 8'h00;
			o_reg_target_mv <= 12'h000;
		end else begin
			o_dac_mv <= (cur_code_q == vid_softstart_pkg::CODE_NO_LOAD) ? 11'h000 : dac_w;
			if (state_q == vid_softstart_pkg::ST_SOFTSTART) begin
				o_ramp_mv <= ramp_w;
				o_ramp_ua <= 8'(iramp_prod >> vid_softstart_pkg::SS_SHIFT);
				o_reg_target_mv <= (ramp_w < {1'b0, o_dac_mv}) ? ramp_w
					: {1'b0, o_dac_mv};
			end else if (state_q == vid_softstart_pkg::ST_RUN) begin
				o_ramp_mv <= 12'h000;
				o_ramp_ua <= 8'h00;
				o_reg_target_mv <= {1'b0, o_dac_mv};
			end else begin
				o_ramp_mv <= 12'h000;
				o_ramp_ua <= 8'h00;
				o_reg_target_mv <= 12'h000;
			end
		end
	end

	// pwm: modulator bits pass through; enables drop at once in shutdown
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_pwm_o <= 4'h0;
		end else begin
			o_pwm_o <= i_pwm_mod;
		end
	end
	assign o_pwm_oe = {4{state_q != vid_softstart_pkg::ST_SHUTDOWN}};
	assign o_soft_start = (state_q == vid_softstart_pkg::ST_SOFTSTART);

	// open drain: pin only ever pulled low, never driven high
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pg_q <= 1'b0;
		end else begin
			pg_q <= enable_ok && (state_q != vid_softstart_pkg::ST_SHUTDOWN)
				&& i_output_above_uv && !i_fault;
		end
	end
	assign o_power_ok_output_o = 1'b0;
	assign o_power_ok_output_oe = !pg_q;

	assign events[vid_softstart_pkg::EV_SHUTDOWN] = !enable_ok
		&& (state_q != vid_softstart_pkg::ST_SHUTDOWN);
	assign events[vid_softstart_pkg::EV_SS_DONE] = enable_ok && ss_done
		&& (state_q == vid_softstart_pkg::ST_SOFTSTART);
	assign events[vid_softstart_pkg::EV_CODE_TAKEN] = code_taken;
	assign events[vid_softstart_pkg::EV_POWER_FAIL] = pg_q && !(enable_ok
		&& i_output_above_uv && !i_fault);

	// a new event beats a simultaneous write-one clear
	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= vid_softstart_pkg::STATUS_RESET;
		end else begin
			status_q <= (status_q & ~((i_reg_wr && i_reg_addr == vid_softstart_pkg::REG_STATUS)
				? i_reg_wdata[3:0] : 4'h0)) | events;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mask_q <= vid_softstart_pkg::MASK_RESET;
		end else if (i_reg_wr && i_reg_addr == vid_softstart_pkg::REG_MASK) begin
			mask_q <= i_reg_wdata[3:0];
		end
	end
	assign o_irq = |(status_q & mask_q);

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				vid_softstart_pkg::REG_STATUS: o_reg_rdata <= {28'h0000000, status_q};
				vid_softstart_pkg::REG_MASK: o_reg_rdata <= {28'h0000000, mask_q};
				vid_softstart_pkg::REG_STATE: o_reg_rdata <= {8'h00, o_dac_mv, target_code_q,
					cur_code_q, pg_q, state_q};
				default: o_reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_reg_rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!rst_n_q);

	AST_SAMPLE_ONLY_AT_TICK: assert property (!tick |=> $stable(sampled_q))
		else $error("code sampled between cycle starts");
	AST_TARGET_NEEDS_TWO_TICKS: assert property ($changed(target_code_q)
		|-> $past(tick) && $past(pend_valid_q) && target_code_q == $past(pend_code_q))
		else $error("target code taken without validation");
	AST_STEP_ONE_ON_TICK: assert property ((state_q != vid_softstart_pkg::ST_SHUTDOWN
		&& $past(state_q) != vid_softstart_pkg::ST_SHUTDOWN && $changed(cur_code_q))
		|-> $past(tick) && $past(step_phase_q)
		&& (cur_code_q == $past(cur_code_q) + 5'h01
		|| cur_code_q == $past(cur_code_q) - 5'h01))
		else $error("reference step not single or off cadence");
	AST_PWM_HIZ: assert property (!enable_ok |=> o_pwm_oe == 4'h0)
		else $error("pwm driven in shutdown");
	AST_START_AT_ONCE: assert property ((state_q == vid_softstart_pkg::ST_SHUTDOWN && enable_ok)
		|=> state_q == vid_softstart_pkg::ST_SOFTSTART && ss_cnt_q == 11'h000)
		else $error("soft-start not begun when enabled");
	AST_NO_START_WITHOUT_POR: assert property (!i_supply_por_ok && i_enable_above
		|=> state_q == vid_softstart_pkg::ST_SHUTDOWN)
		else $error("enable acted before power-on");
	AST_OSC_STOPPED: assert property (!i_freq_select_disable |-> !tick ##1
		state_q == vid_softstart_pkg::ST_SHUTDOWN)
		else $error("oscillator ran while disabled");
	AST_NO_LOAD_SHUTS: assert property (sampled_q == vid_softstart_pkg::CODE_NO_LOAD
		|=> state_q == vid_softstart_pkg::ST_SHUTDOWN)
		else $error("no-load code did not shut down");
	AST_SS_LENGTH: assert property ((state_q == vid_softstart_pkg::ST_SOFTSTART && tick
		&& enable_ok) |=> (ss_cnt_q == $past(ss_cnt_q) + 11'h001)
		&& ((state_q == vid_softstart_pkg::ST_RUN) == ($past(ss_cnt_q) == 11'h7ff)))
		else $error("soft-start count wrong");
	AST_RAMP_BELOW_REF: assert property (state_q == vid_softstart_pkg::ST_SOFTSTART
		&& $past(state_q) == vid_softstart_pkg::ST_SOFTSTART
		|=> o_reg_target_mv <= {1'b0, $past(o_dac_mv)} && o_reg_target_mv <= o_ramp_mv)
		else $error("target above reference or ramp");
	AST_RAMP_I_START: assert property ((state_q == vid_softstart_pkg::ST_SOFTSTART
		&& ss_cnt_q == 11'h000) |=> o_ramp_ua == 8'ha0 && o_ramp_mv == 12'h000)
		else $error("ramp start values wrong");
	AST_PG_LOW_SHUT: assert property (!enable_ok |=> o_power_ok_output_oe)
		else $error("power good released in shutdown");
	AST_PG_FAULT: assert property (pg_q && i_fault |=> o_power_ok_output_oe
		&& status_q[vid_softstart_pkg::EV_POWER_FAIL])
		else $error("fault did not pull power good low");

	COV_SS_DONE: cover property (state_q == vid_softstart_pkg::ST_SOFTSTART
		##1 state_q == vid_softstart_pkg::ST_RUN);
	COV_CODE_STEP: cover property (state_q != vid_softstart_pkg::ST_SHUTDOWN
		&& $changed(cur_code_q));
	COV_PG_HIGH: cover property ($fell(o_power_ok_output_oe));
	COV_NO_LOAD: cover property (state_q == vid_softstart_pkg::ST_RUN
		##1 sampled_q == vid_softstart_pkg::CODE_NO_LOAD);
endmodule

// ### test/proc_drv_model.sv
// far side model: processor code pins and output rail seen by the comparators
`timescale 1ns/100ps
module proc_drv_model #(
	parameter int UV_DELAY = 20
) (
	input wire logic i_mclk,
	input wire logic [3:0] i_pwm_oe,
	input wire logic [4:0] i_code_cmd,
	output logic [4:0] o_voltage_id_code,
	output logic o_output_above_uv
);
	logic [4:0] code_q = 5'h1f;
	logic above_q = 1'b0;
	int up_cnt_q = 0;
	assign o_voltage_id_code = code_q;
	assign o_output_above_uv = above_q;
	// pins follow the processor one edge late, as a real driver would
	always @(posedge i_mclk) begin
		code_q <= i_code_cmd;
	end
	// rail only climbs while every phase is driven; collapses at once otherwise
	always @(posedge i_mclk) begin
		if (i_pwm_oe !== 4'hf) begin
			up_cnt_q <= 0;
			above_q <= 1'b0;
		end else begin
			up_cnt_q <= up_cnt_q + 1;
			above_q <= (up_cnt_q >= UV_DELAY);
		end
	end
endmodule

// ### test/tb_top.sv
// self-checking bench for the code sampling and soft-start sequencer
`timescale 1ns/100ps
module tb_top;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_supply_por_ok = 1'b0;
	logic i_enable_above = 1'b1;
	logic i_freq_select_disable = 1'b1;
	logic i_fault = 1'b0;
	logic [3:0] i_pwm_mod = 4'h5;
	logic [3:0] i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [4:0] code_cmd = 5'h0a;
	logic [4:0] code_pins;
	logic above_uv;
	logic [31:0] o_reg_rdata;
	logic o_irq;
	logic [3:0] o_pwm_o;
	logic [3:0] o_pwm_oe;
	logic pok_o;
	logic pok_oe;
	logic [10:0] o_dac_mv;
	logic [11:0] o_ramp_mv;
	logic [7:0] o_ramp_ua;
	logic [11:0] o_reg_target_mv;
	logic o_soft_start;
	logic [31:0] rdat;
	int mismatches = 0;
	int checks = 0;

	always #20 i_mclk = ~i_mclk;

	vid_softstart_sequencer uut (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_supply_por_ok(i_supply_por_ok), .i_enable_above(i_enable_above),
		.i_freq_select_disable(i_freq_select_disable), .i_voltage_id_code(code_pins),
		.i_output_above_uv(above_uv), .i_fault(i_fault), .i_pwm_mod(i_pwm_mod),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq), .o_pwm_o(o_pwm_o),
		.o_pwm_oe(o_pwm_oe), .o_power_ok_output_o(pok_o), .o_power_ok_output_oe(pok_oe),
		.o_dac_mv(o_dac_mv), .o_ramp_mv(o_ramp_mv), .o_ramp_ua(o_ramp_ua),
		.o_reg_target_mv(o_reg_target_mv), .o_soft_start(o_soft_start));

	proc_drv_model far (.i_mclk(i_mclk), .i_pwm_oe(o_pwm_oe), .i_code_cmd(code_cmd),
		.o_voltage_id_code(code_pins), .o_output_above_uv(above_uv));

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// settle past the edge so the design's updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_mclk);
		i_reg_rd <= 1'b0;
		#1;
		d = o_reg_rdata;
	endtask

	task automatic wait_ss(input logic v, input int lim);
		int n;
		n = 0;
		while (o_soft_start !== v && n < lim) begin
			cyc(1);
			n++;
		end
		chk(32'(o_soft_start), 32'(v));
		if (n >= lim) begin
			close_out();
		end
	endtask

	initial begin
		repeat (4) @(posedge i_mclk);
		i_resetn <= 1'b1;
		cyc(4);
		chk(32'(pok_oe), 32'h1);
		rd(vid_softstart_pkg::REG_MASK, rdat);
		chk(rdat, 32'h0);
		wr(4'hc, 32'hffffffff);
		rd(4'hc, rdat);
		chk(rdat, 32'h0);
		// enable high but supply not yet up: must stay off
		cyc(300);
		chk(32'(o_soft_start), 32'h0);
		chk(32'(o_pwm_oe), 32'h0);
		@(posedge i_mclk);
		i_supply_por_ok <= 1'b1;
		wait_ss(1'b1, 300);
		cyc(2);
		chk(32'(o_pwm_oe), 32'hf);
		chk(32'(o_ramp_ua), 32'ha0);
		chk(32'(o_ramp_mv), 32'h0);
		chk(32'(o_reg_target_mv), 32'h0);
		chk(32'(o_dac_mv), 32'h514);
		chk(32'(o_pwm_o), 32'h5);
		cyc(50);
		chk(32'(pok_oe), 32'h0);
		chk(32'(pok_o), 32'h0);
		// short glitch between two sampling instants is never seen
		@(posedge i_mclk);
		code_cmd <= 5'h04;
		cyc(10);
		@(posedge i_mclk);
		code_cmd <= 5'h0a;
		cyc(200);
		chk(32'(o_dac_mv), 32'h514);
		// held change: pending after one tick, taken after the next
		@(posedge i_mclk);
		code_cmd <= 5'h09;
		cyc(90);
		chk(32'(o_dac_mv), 32'h514);
		cyc(100);
		chk(32'(o_dac_mv), 32'h514);
		chk(32'(o_ramp_ua < 8'ha0), 32'h1);
		chk(32'(o_ramp_mv != 12'h0), 32'h1);
		chk(32'(o_reg_target_mv), 32'(o_ramp_mv));
		rd(vid_softstart_pkg::REG_STATE, rdat);
		chk(32'(rdat[12:8]), 32'h09);
		chk(32'(rdat[7:3]), 32'h0a);
		chk(32'(rdat[1:0]), 32'h1);
		wr(vid_softstart_pkg::REG_MASK, 32'h4);
		cyc(1);
		chk(32'(o_irq), 32'h1);
		wr(vid_softstart_pkg::REG_STATUS, 32'hf);
		cyc(1);
		chk(32'(o_irq), 32'h0);
		// fault drops power good; sticky status keeps the interrupt
		@(posedge i_mclk);
		i_fault <= 1'b1;
		cyc(3);
		chk(32'(pok_oe), 32'h1);
		wr(vid_softstart_pkg::REG_MASK, 32'h8);
		@(posedge i_mclk);
		i_fault <= 1'b0;
		cyc(3);
		chk(32'(pok_oe), 32'h0);
		chk(32'(o_irq), 32'h1);
		wr(vid_softstart_pkg::REG_STATUS, 32'h8);
		cyc(1);
		chk(32'(o_irq), 32'h0);
		// first step lands only on the second cycle start after validation
		cyc(20);
		chk(32'(o_dac_mv), 32'h514);
		cyc(100);
		chk(32'(o_dac_mv), 32'h52d);
		// grounded disable pin: shutdown, then restart on release
		@(posedge i_mclk);
		i_freq_select_disable <= 1'b0;
		cyc(2);
		chk(32'(o_pwm_oe), 32'h0);
		chk(32'(pok_oe), 32'h1);
		rd(vid_softstart_pkg::REG_STATUS, rdat);
		chk(32'(rdat[0]), 32'h1);
		@(posedge i_mclk);
		i_freq_select_disable <= 1'b1;
		wait_ss(1'b1, 300);
		// no-load code shuts down; any other code restarts
		@(posedge i_mclk);
		code_cmd <= 5'h1f;
		wait_ss(1'b0, 300);
		chk(32'(o_pwm_oe), 32'h0);
		@(posedge i_mclk);
		code_cmd <= 5'h00;
		wait_ss(1'b1, 300);
		// restart keeps the old reference until the new code is validated and stepped
		cyc(2);
		chk(32'(o_dac_mv), 32'h52d);
		cyc(1900);
		chk(32'(o_dac_mv), 32'h60e);
		@(posedge i_mclk);
		code_cmd <= 5'h1e;
		cyc(1000);
		chk(32'(o_dac_mv), 32'h5aa);
		cyc(5300);
		chk(32'(o_dac_mv), 32'h320);
		close_out();
	end
endmodule
